// ===== logic/stm_pkg.sv
// Shared constants for the standard timer block.
// Assumes a 32-bit APB master on pclk.
package stm_pkg;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned CMP_P_W = 8;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_CTRL1 = 8'h04;
  localparam logic [7:0] ADDR_CNT = 8'h08;
  localparam logic [7:0] ADDR_CMPA = 8'h0c;
  localparam logic [7:0] ADDR_CMPP = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  // Control word zero fields
  localparam int unsigned BIT_ON = 3;
  // Control word one fields
  localparam int unsigned BIT_MODE_HI = 7;
  localparam int unsigned BIT_MODE_LO = 6;
  localparam int unsigned BIT_PIN_HI = 5;
  localparam int unsigned BIT_PIN_LO = 4;
  localparam int unsigned BIT_INIT = 3;
  localparam int unsigned BIT_INV = 2;
  localparam int unsigned BIT_SWAP = 1;
  localparam int unsigned BIT_CLRSEL = 0;
  // Status fields, write one to clear
  localparam int unsigned BIT_FLAG_A = 0;
  localparam int unsigned BIT_FLAG_P = 1;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] PIN_NONE = 2'h0;
  localparam logic [1:0] PIN_LOW = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  localparam logic [1:0] PIN_TOGGLE = 2'h3;
  typedef enum logic [2:0] {
    OP_CMP    = 3'b000,
    OP_TMR    = 3'b001,
    OP_PWM    = 3'b011,
    OP_PULSE  = 3'b010,
    OP_UNDEF  = 3'b110
  } stm_op_t;
endpackage

// ===== logic/stm_apb_regs.sv
// APB slave holding the control, compare and status words of the timer.
// Assumes a single pclk domain; no wait states, no error answer.
`timescale 1ns/1ns
module stm_apb_regs (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Core side
  input  wire logic [15:0] count,
  input  wire logic        set_a,
  input  wire logic        set_p,
  input  wire logic        auto_off,
  output logic             on_q,
  output logic      [7:0]  ctrl1_q,
  output logic      [15:0] cmp_a_q,
  output logic      [7:0]  cmp_p_q,
  output logic             flag_a_q,
  output logic             flag_p_q
);
  logic        wr;
  logic        on_d;
  logic [7:0]  ctrl1_d;
  logic [15:0] cmp_a_d;
  logic [7:0]  cmp_p_d;
  logic        flag_a_d;
  logic        flag_p_d;
  logic [31:0] rd;

  assign wr      = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    on_d     = on_q;
    ctrl1_d  = ctrl1_q;
    cmp_a_d  = cmp_a_q;
    cmp_p_d  = cmp_p_q;
    flag_a_d = flag_a_q;
    flag_p_d = flag_p_q;
    if (wr) begin
      case (paddr)
        stm_pkg::ADDR_CTRL0: on_d = pwdata[stm_pkg::BIT_ON];
        stm_pkg::ADDR_CTRL1: ctrl1_d = pwdata[7:0];
        stm_pkg::ADDR_CMPA:  cmp_a_d = pwdata[15:0];
        stm_pkg::ADDR_CMPP:  cmp_p_d = pwdata[7:0];
        stm_pkg::ADDR_STAT: begin
          if (pwdata[stm_pkg::BIT_FLAG_A]) flag_a_d = 1'b0;
          if (pwdata[stm_pkg::BIT_FLAG_P]) flag_p_d = 1'b0;
        end
        default: ;
      endcase
    end
    // Hardware stop wins over a same-cycle software write
    if (auto_off) on_d = 1'b0;
    // Set wins over clear
    if (set_a) flag_a_d = 1'b1;
    if (set_p) flag_p_d = 1'b1;
    rd = 32'h0;
    case (paddr)
      stm_pkg::ADDR_CTRL0: rd[stm_pkg::BIT_ON] = on_q;
      stm_pkg::ADDR_CTRL1: rd[7:0] = ctrl1_q;
      stm_pkg::ADDR_CNT:   rd[15:0] = count;
      stm_pkg::ADDR_CMPA:  rd[15:0] = cmp_a_q;
      stm_pkg::ADDR_CMPP:  rd[7:0] = cmp_p_q;
      stm_pkg::ADDR_STAT:  rd[1:0] = {flag_p_q, flag_a_q};
      default:             rd = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q     <= 1'b0;
      ctrl1_q  <= stm_pkg::CTRL1_RESET;
      cmp_a_q  <= 16'h0;
      cmp_p_q  <= 8'h0;
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
      prdata   <= 32'h0;
    end else begin
      on_q     <= on_d;
      ctrl1_q  <= ctrl1_d;
      cmp_a_q  <= cmp_a_d;
      cmp_p_q  <= cmp_p_d;
      flag_a_q <= flag_a_d;
      flag_p_q <= flag_p_d;
      prdata   <= (psel & ~penable & ~pwrite) ? rd : prdata;
    end
  end
endmodule

// ===== logic/stm_timer.sv
// Standard 16-bit timer: counter, two comparators, four operating modes.
// Assumes software programs registers over APB, one clock pclk.
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
module stm_timer #(
  parameter int unsigned CNT_W = stm_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer pin and flags
  output logic             timer_out,
  output logic             timer_out_en,
  output logic             match_a_flag,
  output logic             match_p_flag
);
  logic             on_q;
  logic [7:0]       ctrl1_q;
  logic [15:0]      cmp_a_q;
  logic [7:0]       cmp_p_q;
  logic             on_prev_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             pin_q;
  logic             pin_d;
  logic             set_a;
  logic             set_p;
  logic             auto_off;
  logic             on_rise;
  logic             hit_a;
  logic             hit_p;
  logic             ovf;
  logic             clr;
  logic             pwm_act;
  logic [16:0]      period_v;
  logic [16:0]      duty_v;
  logic [16:0]      pos_v;
  stm_pkg::stm_op_t op;

  // Operating mode from mode field and pin function
  function automatic stm_pkg::stm_op_t decode_op(input logic [7:0] c1);
    logic [1:0] m;
    m = {c1[stm_pkg::BIT_MODE_HI], c1[stm_pkg::BIT_MODE_LO]};
    case (m)
      stm_pkg::MODE_CMP: decode_op = stm_pkg::OP_CMP;
      stm_pkg::MODE_TMR: decode_op = stm_pkg::OP_TMR;
      stm_pkg::MODE_PWM:
        decode_op = c1[stm_pkg::BIT_PIN_LO] & c1[stm_pkg::BIT_PIN_HI]
                  ? stm_pkg::OP_PULSE : stm_pkg::OP_PWM;
      default: decode_op = stm_pkg::OP_UNDEF;
    endcase
  endfunction

  stm_apb_regs u_regs (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .pwdata   (pwdata),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .count    (cnt_q),
    .set_a    (set_a),
    .set_p    (set_p),
    .auto_off (auto_off),
    .on_q     (on_q),
    .ctrl1_q  (ctrl1_q),
    .cmp_a_q  (cmp_a_q),
    .cmp_p_q  (cmp_p_q),
    .flag_a_q (match_a_flag),
    .flag_p_q (match_p_flag)
  );

  assign op      = decode_op(ctrl1_q);
  assign on_rise = on_q & ~on_prev_q;
  // P compare points land only on counts of the form value times 256; A matches any count
  assign hit_a   = on_q & (cnt_q == cmp_a_q);
  assign hit_p   = on_q & (cnt_q[CNT_W-1:CNT_W-8] == cmp_p_q)
                 & (cnt_q[CNT_W-9:0] == '0);
  assign ovf     = on_q & (cnt_q == '1);

  // Clear, flag and stop decisions per mode
  always_comb begin
    clr      = 1'b0;
    set_a    = 1'b0;
    set_p    = 1'b0;
    auto_off = 1'b0;
    case (op)
      stm_pkg::OP_CMP, stm_pkg::OP_TMR: begin
        // Timer mode shares this path
        if (ctrl1_q[stm_pkg::BIT_CLRSEL]) begin
          // A clear, P flag suppressed
          // Zero A never matches; counter wraps at FFFF
          set_a = hit_a & (cmp_a_q != 16'h0) & (cnt_q != '0);
          clr   = set_a | ovf;
        end else begin
          // P match, or wrap when P is zero
          set_a = hit_a & (cmp_a_q != 16'h0);
          set_p = (cmp_p_q == 8'h0) ? ovf : hit_p & (cnt_q != '0);
          clr   = set_p | ovf;
        end
      end
      stm_pkg::OP_PWM: begin
        // Both flags, clear-select ignored
        clr   = (cnt_q == period_v[15:0] - 16'h1) & on_q;
        // Period comparator matches at the terminal count, as the counter never reaches it
        set_a = ctrl1_q[stm_pkg::BIT_SWAP] ? clr : hit_a;
        set_p = ctrl1_q[stm_pkg::BIT_SWAP] ? hit_p : clr;
      end
      stm_pkg::OP_PULSE: begin
        // A match stops counter-on and flags
        set_a    = hit_a & (cnt_q != '0);
        auto_off = set_a;
      end
      default: ;
    endcase
  end

  // PWM period and duty in clocks
  always_comb begin
    logic [16:0] p_clk;
    p_clk = (cmp_p_q == 8'h0) ? 17'h10000 : {1'b0, cmp_p_q, 8'h0};
    if (ctrl1_q[stm_pkg::BIT_SWAP]) begin
      period_v = (cmp_a_q == 16'h0) ? 17'h10000 : {1'b0, cmp_a_q};
      duty_v   = p_clk;
    end else begin
      period_v = p_clk;
      duty_v   = {1'b0, cmp_a_q};
    end
    pos_v   = {1'b0, cnt_q};
    // Duty at or beyond period holds active
    pwm_act = (duty_v >= period_v) | (pos_v < duty_v);
  end

  // Counter
  always_comb begin
    cnt_d = cnt_q;
    if (on_rise) begin
      cnt_d = '0;
    end else if (on_q) begin
      // Pulse mode never clears mid-run
      if (clr && op != stm_pkg::OP_PULSE) begin
        cnt_d = '0;
      end else if (op == stm_pkg::OP_PULSE && auto_off) begin
        cnt_d = cnt_q;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  // Output pin
  always_comb begin
    logic       act;
    logic [1:0] pf;
    act   = ctrl1_q[stm_pkg::BIT_INIT];
    pf    = {ctrl1_q[stm_pkg::BIT_PIN_HI], ctrl1_q[stm_pkg::BIT_PIN_LO]};
    pin_d = pin_q;
    case (op)
      stm_pkg::OP_CMP: begin
        if (on_rise) begin
          pin_d = act;
        end else if (set_a) begin
          // Only the A flag moves the pin
          case (pf)
            stm_pkg::PIN_LOW:    pin_d = 1'b0;
            stm_pkg::PIN_HIGH:   pin_d = 1'b1;
            stm_pkg::PIN_TOGGLE: pin_d = ~pin_q;
            default:             pin_d = pin_q;
          endcase
        end
      end
      stm_pkg::OP_PWM: begin
        // Counting continues under forced levels
        case (pf)
          stm_pkg::PIN_NONE: pin_d = ~act;
          stm_pkg::PIN_LOW:  pin_d = act;
          default:           pin_d = on_q ? (pwm_act ? act : ~act) : ~act;
        endcase
      end
      stm_pkg::OP_PULSE: begin
        // Leading edge on rise, trailing on stop
        if (on_rise) begin
          pin_d = act;
        end else if (!on_q || auto_off) begin
          pin_d = ~act;
        end
      end
      default: pin_d = pin_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_prev_q <= 1'b0;
      cnt_q     <= '0;
      pin_q     <= 1'b0;
    end else begin
      on_prev_q <= on_q;
      cnt_q     <= cnt_d;
      pin_q     <= pin_d;
    end
  end

  // Invert applies last; timer mode releases the pin
  assign timer_out    = pin_q ^ (ctrl1_q[stm_pkg::BIT_INV] & (op != stm_pkg::OP_TMR));
  assign timer_out_en = (op == stm_pkg::OP_TMR) | (op == stm_pkg::OP_UNDEF);
endmodule

// ===== sim/stm_timer_monitor.sv
// Pin and flag checker for stm_timer.
// Assumes writes take effect at the APB access edge.
`timescale 1ns/1ns
module stm_timer_monitor (
  // Clock and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Pin and flags
  input wire logic        timer_out,
  input wire logic        timer_out_en,
  input wire logic        match_a_flag,
  input wire logic        match_p_flag
);
  logic [7:0]  c1_q, c1_d;
  logic [15:0] ca_q, ca_d;
  logic        on_q, on_d, wr;
  // Shadow only; pulse auto-off is not mirrored
  assign wr = psel && penable && pwrite;
  always_comb begin
    c1_d = c1_q;
    ca_d = ca_q;
    on_d = on_q;
    if (wr && paddr == stm_pkg::ADDR_CTRL1) c1_d = pwdata[7:0];
    if (wr && paddr == stm_pkg::ADDR_CMPA) ca_d = pwdata[15:0];
    if (wr && paddr == stm_pkg::ADDR_CTRL0) on_d = pwdata[3];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= 8'h00;
      ca_q <= 16'h0000;
      on_q <= 1'b0;
    end else begin
      c1_q <= c1_d;
      ca_q <= ca_d;
      on_q <= on_d;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  drive_en_a: assert property (!c1_q[6] && $stable(c1_q) |-> !timer_out_en)
    else $error("pin not driven");
  tmr_release_a: assert property (c1_q[7:6] == 2'h3 && $stable(c1_q) |-> timer_out_en)
    else $error("pin driven in timer mode");
  a_zero_flag_a: assert property (
    $rose(match_a_flag) && $stable(ca_q) && c1_q[7:6] == 2'h3 |-> ca_q != 16'h0)
    else $error("A flag with A zero");
  p_flag_off_a: assert property (
    $rose(match_p_flag) && $stable(c1_q) |-> !(c1_q[0] && c1_q[7:6] != 2'h2))
    else $error("P flag with A clear");
  pin_hold_a: assert property (
    (on_q && c1_q[7:4] == 4'h0 && $stable(c1_q))[*4] |-> $stable(timer_out))
    else $error("pin moved with no function");
  init_level_a: assert property (
    $rose(on_q) && c1_q[7:6] == 2'h0 |-> ##[1:2] timer_out == (c1_q[3] ^ c1_q[2]))
    else $error("initial level missing");
  pulse_start_a: assert property (
    $rose(on_q) && c1_q[7:4] == 4'hb |-> ##[1:2] timer_out == (c1_q[3] ^ c1_q[2]))
    else $error("pulse lead missing");
  pulse_end_a: assert property (
    $rose(match_a_flag) && c1_q[7:4] == 4'hb |-> ##[0:2] timer_out != (c1_q[3] ^ c1_q[2]))
    else $error("pulse trail missing");
endmodule

bind stm_timer stm_timer_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .timer_out, .timer_out_en, .match_a_flag, .match_p_flag);

// ===== sim/stm_timer_tb.sv
// Bench for stm_timer: APB tasks set up every mode, pin and flags compared.
// Assumes the slave answers; a stalled pready is cut off by a bound.
`timescale 1ns/1ns
module stm_timer_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        timer_out, timer_out_en, match_a_flag, match_p_flag;
  int          error_cnt, checks_done, hi;

  stm_timer dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer_out, .timer_out_en, .match_a_flag, .match_p_flag);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) error_cnt++;
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask

  // Off first: mode and pin function must not change while running
  task automatic cfg(input logic [7:0] c1, input logic [15:0] a, input logic [7:0] p);
    xfer(1'b1, stm_pkg::ADDR_CTRL0, 32'h0);
    xfer(1'b1, stm_pkg::ADDR_CMPA, {16'h0, a});
    xfer(1'b1, stm_pkg::ADDR_CMPP, {24'h0, p});
    xfer(1'b1, stm_pkg::ADDR_STAT, 32'h3);
    xfer(1'b1, stm_pkg::ADDR_CTRL1, {24'h0, c1});
    xfer(1'b1, stm_pkg::ADDR_CTRL0, 32'h8);
    repeat (3) @(posedge pclk);
  endtask

  task automatic wait_flag(input logic p);
    int n;
    n = 0;
    while ((p ? match_p_flag : match_a_flag) !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk("flag_wait", 1, n < 2000);
    repeat (3) @(posedge pclk);
  endtask

  // Back-to-back reads are three clocks apart
  task automatic cnt_step(input logic [31:0] exp);
    logic [31:0] r2;
    rd(stm_pkg::ADDR_CNT);
    r2 = rv;
    rd(stm_pkg::ADDR_CNT);
    chk("cnt_step", exp, rv - r2);
  endtask

  task automatic pwm(input logic [7:0] c1, input logic [15:0] a, input int eh,
                     input logic [1:0] fl);
    cfg(c1, a, 8'h1);
    hi = 0;
    repeat (512) begin
      @(posedge pclk);
      if (timer_out === 1'b1) hi++;
    end
    chk("pwm_high", eh, hi);
    chk("pwm_flags", fl, {match_p_flag, match_a_flag});
  endtask

  task automatic results();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    chk("pin_rst", 0, {timer_out, timer_out_en});
    xfer(1'b1, 8'h18, 32'hffffffff);
    rd(8'h18);
    chk("unmapped", 0, rv);
    rd(stm_pkg::ADDR_CTRL1);
    chk("ctrl1_rst", 0, rv);
    $display("reset test done");
    cfg(8'h08, 16'h40, 8'h1);
    chk("init_level", 1, timer_out);
    wait_flag(1'b0);
    chk("p_early", 0, match_p_flag);
    wait_flag(1'b1);
    chk("pin_on_p", 1, timer_out);
    rd(stm_pkg::ADDR_CNT);
    chk("p_clear", 1, rv < 16);
    rd(stm_pkg::ADDR_STAT);
    chk("both_flags", 3, rv);
    cfg(8'h31, 16'h140, 8'h1);
    wait_flag(1'b0);
    chk("pin_toggle", 1, timer_out);
    repeat (400) @(posedge pclk);
    chk("no_p_flag", 0, match_p_flag);
    rd(stm_pkg::ADDR_CNT);
    chk("a_clear", 1, rv < 32'h140);
    $display("compare test done");
    cfg(8'hc0, 16'h0, 8'h0);
    repeat (300) @(posedge pclk);
    chk("a_zero", 0, match_a_flag);
    cnt_step(3);
    cfg(8'hc0, 16'h40, 8'h1);
    wait_flag(1'b1);
    chk("tmr", 7, {timer_out_en, match_p_flag, match_a_flag});
    xfer(1'b1, stm_pkg::ADDR_CTRL0, 32'h0);
    cnt_step(0);
    $display("timer test done");
    pwm(8'ha8, 16'h40, 128, 2'h3);
    pwm(8'hac, 16'h40, 384, 2'h3);
    pwm(8'haa, 16'h80, 512, 2'h1);
    pwm(8'h98, 16'h40, 512, 2'h3);
    pwm(8'h88, 16'h40, 0, 2'h3);
    $display("pwm test done");
    cfg(8'hb8, 16'h20, 8'h0);
    chk("pulse_lead", 1, timer_out);
    wait_flag(1'b0);
    chk("pulse_trail", 0, timer_out);
    rd(stm_pkg::ADDR_CTRL0);
    chk("auto_off", 0, rv[3]);
    cnt_step(0);
    cfg(8'hb8, 16'h1000, 8'h0);
    xfer(1'b1, stm_pkg::ADDR_CTRL0, 32'h0);
    repeat (3) @(posedge pclk);
    chk("soft_end", 0, timer_out);
    $display("pulse test done");
    results();
  end

  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    results();
  end
endmodule
